// ---- rtl/scd_decoder.sv ----
`timescale 1ns/10ps
module scd_decoder (
  input  wire logic                  clk,          // System clock
  input  wire logic                  srst,         // Sync reset
  input  wire logic                  link_is_spi,  // Link runs as SPI
  input  wire logic [1:0]            mode,         // Current operating mode
  input  wire logic                  frame_start,  // New command frame begins
  input  wire logic                  frame_end,    // Command frame ends
  input  wire logic                  byte_vld,     // Received byte strobe
  input  wire logic [7:0]            byte_in,      // Received byte
  input  wire logic                  conv_done,    // Conversion finished pulse
  input  wire logic [23:0]           conv_result,  // Raw converter result
  input  wire logic                  cyclic_active,// Cyclic measuring running
  output logic                       conv_start,   // Conversion start pulse
  output scd_pkg::scd_conv_req_t     conv_req,     // Conversion request
  output logic                       power_down,   // Halt and sleep pulse
  output logic                       busy,         // Command executing
  output logic                       setup_alt,    // Alternate setup selected
  output logic [7:0]                 status,       // Status byte
  output logic [23:0]                result,       // Latest result word
  output logic                       resp_vld      // Status plus result ready
);
  // ==========================================================
  // Command sequencing
  typedef enum logic [1:0] {
    SCD_IDLE = 2'b00,
    SCD_WORD = 2'b01,
    SCD_CONV = 2'b10
  } scd_state_t;

  scd_state_t  state;
  scd_state_t  next_state;
  logic [2:0]  raw_op;
  logic        first_byte;
  logic        cmd_take;
  logic        is_raw;
  logic        word_done;
  logic [15:0] word;

  assign cmd_take = byte_vld && first_byte && state == SCD_IDLE && !cyclic_active; // [RL16]
  assign is_raw   = byte_in[7:3] == scd_pkg::CMD_RAW_HI;

  always_ff @(posedge clk)
  begin
    if (srst || frame_end)
    begin
      first_byte <= 1'b0;
    end
    else if (frame_start)
    begin
      first_byte <= 1'b1;
    end
    else if (byte_vld)
    begin
      first_byte <= 1'b0;
    end
  end

  scd_word_capture u_word (
    .clk      (clk),
    .srst     (srst),
    .arm      (cmd_take),
    .abort    (frame_end),
    .byte_vld (byte_vld && state == SCD_WORD),
    .byte_in  (byte_in),
    .done     (word_done),
    .word     (word)
  );

  always_comb
  begin
    next_state = state;
    case (state)
      SCD_IDLE:
      begin
        if (cmd_take && is_raw)
        begin
          next_state = SCD_WORD;
        end
      end
      SCD_WORD:
      begin
        if (word_done)
        begin
          next_state = SCD_CONV; // [RL19]
        end
        else if (frame_end)
        begin
          next_state = SCD_IDLE; // [RL19]
        end
      end
      SCD_CONV:
      begin
        if (conv_done)
        begin
          next_state = SCD_IDLE;
        end
      end
      default:
      begin
        next_state = SCD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state <= SCD_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      raw_op <= 3'h0;
    end
    else if (cmd_take && is_raw)
    begin
      raw_op <= byte_in[2:0];
    end
  end

  // ==========================================================
  // Setup selection; mode input is never altered here [RL18]
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      setup_alt <= 1'b0; // [RL15]
    end
    else if (cmd_take && byte_in == scd_pkg::CMD_SEL_ALT)
    begin
      setup_alt <= 1'b1; // [RL1]
    end
    else if (cmd_take && byte_in == scd_pkg::CMD_SEL_PRIM)
    begin
      setup_alt <= 1'b0; // [RL15]
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      power_down <= 1'b0;
    end
    else
    begin
      // Halt bypasses busy so cyclic or raw work can always be stopped
      power_down <= byte_vld && first_byte
                    && byte_in == scd_pkg::CMD_HALT_CYC; // [RL2]
    end
  end

  // ==========================================================
  // Conversion request; setup sampled at start only [RL17]
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      conv_start <= 1'b0;
      conv_req   <= '0;
    end
    else
    begin
      conv_start <= word_done && state == SCD_WORD; // [RL19]
      if (word_done && state == SCD_WORD)
      begin
        conv_req.temperature  <= raw_op[2];            // [RL9] [RL10] [RL11]
        conv_req.zero_correct <= raw_op[1];            // [RL7] [RL8] [RL11]
        conv_req.host_setup   <= raw_op[0];            // [RL14] [RL6]
        conv_req.fixed_setup  <= raw_op[2] && !raw_op[0]; // [RL9] [RL11]
        conv_req.store_addr   <= setup_alt ? scd_pkg::ADDR_ALTERNATE
                                           : scd_pkg::ADDR_PRIMARY; // [RL5] [RL7]
        if (!raw_op[0])
        begin
          conv_req.setup_word <= 16'h0000;
        end
        else if (raw_op[2])
        begin
          conv_req.setup_word <= word & scd_pkg::TEMP_KEEP_MASK; // [RL10]
        end
        else
        begin
          conv_req.setup_word <= word; // [RL6] [RL8]
        end
      end
    end
  end

  // ==========================================================
  // Result and status
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      result <= 24'h000000;
    end
    else if (state == SCD_CONV && conv_done)
    begin
      result <= conv_result; // [RL14]
    end
  end

  assign busy = state != SCD_IDLE || cyclic_active; // [RL16]

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      status <= 8'h00;
    end
    else
    begin
      status                       <= 8'h00;
      status[scd_pkg::STAT_BUSY]   <= next_state != SCD_IDLE || cyclic_active; // [RL16]
      status[4:3]                  <= mode;
      status[scd_pkg::STAT_SETUP]  <= setup_alt; // [RL1] [RL15]
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      resp_vld <= 1'b0;
    end
    else
    begin
      resp_vld <= byte_vld && first_byte && link_is_spi
                  && byte_in[7:4] == scd_pkg::CMD_NOP_HI; // [RL3] [RL4]
    end
  end
endmodule : scd_decoder

// ---- rtl/scd_pkg.sv ----
// Function
// RL1: B1 selects alternate setup, status bit1 set
// RL2: BF halts cyclic work, enters sleep
// RL3: Fx is no-op returning status and result
// RL4: No-op poll honoured only on SPI link
// RL5: A0 uncorrected sensor conversion, selected stored setup
// RL6: A1 sensor conversion with host setup word
// RL7: A2 zero-corrected sensor conversion, stored setup
// RL8: A3 zero-corrected sensor conversion, host setup
// RL9: A4 uncorrected temperature, fixed internal setup
// RL10: A5/A7 temperature with host word, drop 15:12
// RL11: A6 zero-corrected temperature, fixed internal setup
// RL12: Host uses stored-setup zero commands for calibration
// RL13: Host uses host-setup zero commands for evaluation
// RL14: Raw result to output; command lsb picks setup
// RL15: B0 selects primary setup, clears bit1, default
// RL16: Busy in bit5; new commands ignored while busy; code still acts on BF halt and Fx poll while busy
// RL17: Setup select applies only to later measurements
// RL18: Commands accepted in both modes, mode unchanged
// RL19: Full trailing word captured before conversion starts
package scd_pkg;
  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_RAW_BASE  = 8'ha0;
  localparam logic [4:0] CMD_RAW_HI    = 5'h14;
  localparam logic [7:0] CMD_SEL_PRIM  = 8'hb0;
  localparam logic [7:0] CMD_SEL_ALT   = 8'hb1;
  localparam logic [7:0] CMD_HALT_CYC  = 8'hbf;
  localparam logic [3:0] CMD_NOP_HI    = 4'hf;
  // ==========================================================
  // Store locations and status bit positions
  localparam logic [5:0] ADDR_PRIMARY  = 6'h12;
  localparam logic [5:0] ADDR_ALTERNATE = 6'h16;
  localparam int         STAT_BUSY     = 5;
  localparam int         STAT_SETUP    = 1;
  localparam int         TEMP_IGN_MSB  = 15;
  localparam int         TEMP_IGN_LSB  = 12;
  localparam logic [15:0] TEMP_KEEP_MASK = 16'h0fff;
  localparam logic [1:0] MODE_NORMAL   = 2'h0;
  localparam logic [1:0] MODE_COMMAND  = 2'h1;

  // Conversion request handed to the front end
  typedef struct packed {
    logic        temperature; // 1: temperature, 0: sensor
    logic        zero_correct; // Auto-zero correction
    logic        fixed_setup; // Internal fixed setup
    logic        host_setup;  // Setup from host word
    logic [5:0]  store_addr;  // Stored setup location
    logic [15:0] setup_word;  // Host-supplied setup
  } scd_conv_req_t;
endpackage : scd_pkg

// ---- rtl/scd_word_capture.sv ----
`timescale 1ns/10ps
// Collects two trailing bytes, msb first, into one word
module scd_word_capture (
  input  wire logic        clk,      // System clock
  input  wire logic        srst,     // Sync reset
  input  wire logic        arm,      // Start a new capture
  input  wire logic        abort,    // Frame ended early
  input  wire logic        byte_vld, // Data byte strobe
  input  wire logic [7:0]  byte_in,  // Data byte
  output logic             done,     // Word complete pulse
  output logic [15:0]      word      // Captured word
);
  logic [1:0] count;

  always_ff @(posedge clk)
  begin
    if (srst || arm || abort)
    begin
      count <= 2'h0;
    end
    else if (byte_vld && count != 2'h2)
    begin
      count <= count + 2'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      word <= 16'h0000;
    end
    else if (byte_vld && count != 2'h2 && !arm)
    begin
      word <= {word[7:0], byte_in};
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      done <= 1'b0;
    end
    else
    begin
      done <= byte_vld && !arm && !abort && count == 2'h1; // [RL19]
    end
  end
endmodule : scd_word_capture

// ---- testbench/scd_decoder_chk.sv ----
`timescale 1ns/10ps
module scd_decoder_chk (
  input wire logic        clk,           // System clock
  input wire logic        srst,          // Sync reset
  input wire logic        link_is_spi,   // SPI link
  input wire logic        frame_start,   // Frame begin
  input wire logic        frame_end,     // Frame end
  input wire logic        byte_vld,      // Byte strobe
  input wire logic [7:0]  byte_in,       // Byte value
  input wire logic        conv_done,     // Converter done
  input wire logic [23:0] conv_result,   // Converter data
  input wire logic        cyclic_active, // Cyclic running
  input wire logic        power_down,    // Halt pulse
  input wire logic        busy,          // Busy level
  input wire logic        setup_alt,     // Setup select
  input wire logic [7:0]  status,        // Status byte
  input wire logic [23:0] result,        // Result word
  input wire logic        resp_vld       // Poll answer
);
  logic first;
  logic cmd_ok;
  // ==========================================
  // Command byte tracking
  always_ff @(posedge clk)
  begin
    if (srst || frame_end)
    begin
      first <= 1'b0;
    end
    else if (frame_start)
    begin
      first <= 1'b1;
    end
    else if (byte_vld)
    begin
      first <= 1'b0;
    end
  end
  assign cmd_ok = first && byte_vld && !busy;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ==========================================
  // Properties
  alt_select_a: assert property (cmd_ok && byte_in == 8'hb1 |=> setup_alt ##1 status[1])
    else $error("alternate setup not taken");
  prim_select_a: assert property (cmd_ok && byte_in == 8'hb0 |=> !setup_alt ##1 !status[1])
    else $error("primary setup not taken");
  halt_pulse_a: assert property (first && byte_vld && byte_in == 8'hbf |=> power_down)
    else $error("halt gave no power down");
  poll_spi_a: assert property (cmd_ok && byte_in[7:4] == 4'hf && link_is_spi
    |=> resp_vld && result == $past(result)) else $error("poll not answered");
  poll_i2c_a: assert property (cmd_ok && byte_in[7:4] == 4'hf && !link_is_spi
    |=> !resp_vld) else $error("poll answered off spi");
  result_load_a: assert property (conv_done |=> result == $past(conv_result))
    else $error("result not loaded");
  busy_cyclic_a: assert property (cyclic_active |-> busy)
    else $error("not busy while cyclic");
  busy_refuse_a: assert property (first && byte_vld && busy && byte_in[7:4] == 4'hb
    && byte_in != 8'hbf |=> $stable(setup_alt)) else $error("command taken while busy");
endmodule : scd_decoder_chk

bind scd_decoder scd_decoder_chk i_chk (.clk(clk), .srst(srst), .link_is_spi(link_is_spi),
  .frame_start(frame_start), .frame_end(frame_end), .byte_vld(byte_vld), .byte_in(byte_in),
  .conv_done(conv_done),
  .conv_result(conv_result), .cyclic_active(cyclic_active), .power_down(power_down),
  .busy(busy), .setup_alt(setup_alt), .status(status), .result(result), .resp_vld(resp_vld));

// ---- testbench/scd_host_model.sv ----
`timescale 1ns/10ps
module scd_host_model (
  input  wire logic clk,         // System clock
  output logic      frame_start, // Frame begin
  output logic      frame_end,   // Frame end
  output logic      byte_vld,    // Byte strobe
  output logic [7:0] byte_in     // Byte value
);
  initial
  begin
    frame_start = 1'b0;
    frame_end = 1'b0;
    byte_vld = 1'b0;
    byte_in = 8'h5a;
  end
  // Idle data is inverted so a stale byte never looks valid
  task automatic send_frame(input logic [7:0] cmd, input logic [15:0] w, input int nb);
    @(negedge clk) frame_start <= 1'b1;
    @(negedge clk) frame_start <= 1'b0;
    byte_vld <= 1'b1;
    byte_in <= cmd;
    if (nb > 0)
      @(negedge clk) byte_in <= w[15:8];
    if (nb > 1)
      @(negedge clk) byte_in <= w[7:0];
    @(negedge clk) byte_vld <= 1'b0;
    byte_in <= ~byte_in;
    frame_end <= 1'b1;
    @(negedge clk) frame_end <= 1'b0;
  endtask : send_frame
endmodule : scd_host_model

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] word;
    logic [3:0] kind;
    logic [15:0] exp_word;
  } scd_row_t;
  localparam scd_row_t ROWS [8] = '{'{8'ha0, 16'h0000, 4'h0, 16'h0},
    '{8'ha1, 16'habcd, 4'h1, 16'habcd}, '{8'ha2, 16'h0000, 4'h4, 16'h0},
    '{8'ha3, 16'h1234, 4'h5, 16'h1234}, '{8'ha4, 16'h0000, 4'ha, 16'h0},
    '{8'ha5, 16'hfabc, 4'h9, 16'h0abc}, '{8'ha6, 16'h0000, 4'he, 16'h0},
    '{8'ha7, 16'h9876, 4'hd, 16'h0876}};
  logic clk, srst, link_is_spi, cyclic_active, conv_start, power_down;
  logic conv_done = 1'b0;
  logic busy, setup_alt, resp_vld, frame_start, frame_end, byte_vld;
  logic [1:0] mode;
  logic [7:0] byte_in, status;
  logic [23:0] result, exp_res, k;
  logic [23:0] conv_result = 24'h0;
  logic [23:0] n_start = 24'h0, n_resp = 24'h0, n_pdn = 24'h0;
  scd_pkg::scd_conv_req_t conv_req, got_req;
  int error_cnt = 0, n_tests = 0;
  always #4 clk = ~clk;
  scd_host_model i_scd_host_model (.clk(clk), .frame_start(frame_start),
    .frame_end(frame_end), .byte_vld(byte_vld), .byte_in(byte_in));
  scd_decoder i_scd_decoder (.clk(clk), .srst(srst), .link_is_spi(link_is_spi), .mode(mode),
    .frame_start(frame_start), .frame_end(frame_end), .byte_vld(byte_vld), .byte_in(byte_in),
    .conv_done(conv_done), .conv_result(conv_result), .cyclic_active(cyclic_active),
    .conv_start(conv_start), .conv_req(conv_req), .power_down(power_down), .busy(busy),
    .setup_alt(setup_alt), .status(status), .result(result), .resp_vld(resp_vld));
  // ==========================================
  // Converter and pulse monitors
  always @(posedge clk)
  begin
    if (conv_start)
    begin
      n_start = n_start + 24'h1;
      got_req = conv_req;
    end
    if (resp_vld)
      n_resp = n_resp + 24'h1;
    if (power_down)
      n_pdn = n_pdn + 24'h1;
  end
  // Slow answer keeps busy long enough to land a second frame
  always @(posedge clk)
  begin
    if (conv_start)
    begin
      repeat (20) @(negedge clk);
      conv_done <= 1'b1;
      conv_result <= exp_res;
      @(negedge clk) conv_done <= 1'b0;
      conv_result <= ~exp_res;
    end
  end
  // ==========================================
  // Tasks
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 200)
    begin
      error_cnt++;
      $display("Error at %0t: busy never fell", $time);
      report_and_stop();
    end
    @(negedge clk);
  endtask : wait_idle
  task automatic send(input logic [7:0] c, input int nb);
    i_scd_host_model.send_frame(c, 16'h0000, nb);
    repeat (3) @(negedge clk);
  endtask : send
  task automatic run(input scd_row_t r, input logic [5:0] addr);
    k = n_start;
    exp_res = {8'h3c, r.cmd, r.word[7:0]};
    i_scd_host_model.send_frame(r.cmd, r.word, 2);
    wait_idle();
    check(n_start, k + 24'h1);
    check({20'h0, got_req.temperature, got_req.zero_correct, got_req.fixed_setup,
      got_req.host_setup}, {20'h0, r.kind});
    if (r.kind[0])
      check({8'h0, got_req.setup_word}, {8'h0, r.exp_word});
    if (!r.kind[3] && !r.kind[0])
      check({18'h0, got_req.store_addr}, {18'h0, addr});
    check(result, exp_res);
  endtask : run
  // ==========================================
  // Sequence
  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    link_is_spi = 1'b1;
    cyclic_active = 1'b0;
    mode = 2'h0;
    exp_res = 24'h0;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    foreach (ROWS[i])
      run(ROWS[i], 6'h12);
    $display("Raw table done");
    send(8'hb1, 0);
    check({23'h0, status[1]}, 24'h1);
    run(ROWS[2], 6'h16);
    send(8'hb0, 0);
    check({23'h0, setup_alt}, 24'h0);
    i_scd_host_model.send_frame(8'ha1, 16'h0123, 2);
    send(8'hb1, 0);
    check({23'h0, status[5]}, 24'h1);
    k = n_pdn;
    send(8'hbf, 0);
    check(n_pdn, k + 24'h1);
    wait_idle();
    check({23'h0, setup_alt}, 24'h0);
    k = n_start;
    i_scd_host_model.send_frame(8'ha1, 16'h4567, 1);
    repeat (30) @(negedge clk);
    check(n_start, k);
    $display("Refusal tests done");
    k = n_resp;
    send(8'hf5, 0);
    check(n_resp, k + 24'h1);
    link_is_spi = 1'b0;
    send(8'hfa, 0);
    check(n_resp, k + 24'h1);
    link_is_spi = 1'b1;
    mode = 2'h1;
    send(8'hb1, 0);
    check({21'h0, status[4:3], setup_alt}, 24'h3);
    cyclic_active = 1'b1;
    k = n_pdn;
    send(8'hbf, 0);
    check({22'h0, busy, status[5]}, 24'h3);
    check(n_pdn, k + 24'h1);
    cyclic_active = 1'b0;
    mode = 2'h0;
    $display("Mode and halt tests done");
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    check({15'h0, status, setup_alt}, 24'h0);
    check(result, 24'h0);
    $display("Reset test done");
    report_and_stop();
  end
endmodule : tb
